// ==== shared/sbp_pkg.sv ====
`default_nettype none
package sbp_pkg;
    // ----------------------------------------
    // clock and protocol delays
    // ----------------------------------------
    localparam int CLK_MHZ         = 50;
    localparam int T_SETTLE_NS     = 400;
    localparam int T_FREE_NS       = 800;
    localparam int T_SET_NS        = 1800;
    localparam int T_ARB_NS        = 2400;
    localparam int T_ASSERT_NS     = 90;
    localparam int T_DESKEW_NS     = 45;
    localparam int T_CLEAR_NS      = 800;
    localparam int T_CLEAR_FREE_NS = 1200;
    localparam int T_DISC_US       = 200;

    // minimums round up, maximums down
    localparam int N_SETTLE   = (T_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int N_FREE     = (T_FREE_NS * CLK_MHZ + 999) / 1000;
    localparam int N_SET      = (T_SET_NS * CLK_MHZ) / 1000;
    localparam int N_ARB      = (T_ARB_NS * CLK_MHZ + 999) / 1000;
    localparam int N_ASSERT   = (T_ASSERT_NS * CLK_MHZ + 999) / 1000;
    localparam int N_DESKEW2  = (2 * T_DESKEW_NS * CLK_MHZ + 999) / 1000;
    localparam int N_CLEAR    = (T_CLEAR_NS * CLK_MHZ) / 1000;
    localparam int N_CLR_FREE = (T_CLEAR_FREE_NS * CLK_MHZ) / 1000;
    localparam int N_DISC     = T_DISC_US * CLK_MHZ;
    // detection takes exactly the settle time
    localparam int N_DETECT   = N_SETTLE;
    localparam int N_EXCESS   = N_DETECT - N_SETTLE;
    localparam int N_CLR_WIN  = N_CLEAR - N_EXCESS;

    localparam int TMR_W = 16;
    localparam int AGE_W = 8;

    // ----------------------------------------
    // reset values and encodings
    // ----------------------------------------
    localparam logic [7:0] DB_NONE = 8'h00;
    localparam logic [7:0] DB_ONE  = 8'h01;

    typedef enum logic [3:0] {
        PH_FREE    = 4'h0,
        PH_ARB     = 4'h1,
        PH_SEL     = 4'h2,
        PH_RESEL   = 4'h3,
        PH_COMMAND = 4'h4,
        PH_DATA_IN = 4'h5,
        PH_DATA_OUT= 4'h6,
        PH_STATUS  = 4'h7,
        PH_MSG_IN  = 4'h8,
        PH_MSG_OUT = 4'h9
    } sbp_phase_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ARB  = 4'h1,
        ST_WON  = 4'h2,
        ST_SEL  = 4'h3,
        ST_SELW = 4'h4,
        ST_TGT  = 4'h5,
        ST_INIT = 4'h6,
        ST_RSEL = 4'h7,
        ST_DISC = 4'h8
    } sbp_state_t;

    typedef struct packed {
        logic       bsy;
        logic       sel;
        logic       cd_oe;
        logic       cd;
        logic       io_oe;
        logic       io;
        logic       msg_oe;
        logic       msg;
        logic       req;
        logic       ack;
        logic       atn;
        logic [7:0] db_oe;
        logic [7:0] db;
        logic       dbp_oe;
        logic       dbp;
    } sbp_drv_t;

    localparam sbp_drv_t DRV_NONE = '0;
endpackage
`default_nettype wire

// ==== design/sbp_free_det.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbp_free_det
    import sbp_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             bsy_in,
    input  wire logic             sel_in,
    input  wire logic             rst_in,
    output logic                  free_det,
    output logic [AGE_W-1:0]      free_age
);
    // ----------------------------------------
    // quiet counter and age since detection
    // ----------------------------------------
    logic [AGE_W-1:0] quiet_q, quiet_d;
    logic [AGE_W-1:0] age_q, age_d;

    always_comb begin
        quiet_d = quiet_q;
        age_d   = age_q;
        if (bsy_in || sel_in || rst_in) begin
            quiet_d = '0;
            age_d   = '0;
        end else if (quiet_q != AGE_W'(N_DETECT)) begin
            quiet_d = quiet_q + 1'b1;
        end else if (age_q != {AGE_W{1'b1}}) begin
            age_d = age_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            quiet_q <= '0;
            age_q   <= '0;
        end else if (ce) begin
            quiet_q <= quiet_d;
            age_q   <= age_d;
        end
    end

    assign free_det = (quiet_q == AGE_W'(N_DETECT));
    assign free_age = age_q;
endmodule
`default_nettype wire

// ==== design/sbp_bus_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbp_bus_ctrl
    import sbp_pkg::*;
#(
    parameter int DISC_CYC = N_DISC
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             bsy_in,
    input  wire logic             sel_in,
    input  wire logic             rst_in,
    input  wire logic             cd_in,
    input  wire logic             io_in,
    input  wire logic             msg_in,
    input  wire logic             req_in,
    input  wire logic             ack_in,
    input  wire logic             atn_in,
    input  wire logic [7:0]       db_in,
    input  wire logic             dbp_in,
    output logic                  bsy_o,
    output logic                  bsy_oe,
    output logic                  sel_o,
    output logic                  sel_oe,
    output logic                  rst_o,
    output logic                  rst_oe,
    output logic                  cd_o,
    output logic                  cd_oe,
    output logic                  io_o,
    output logic                  io_oe,
    output logic                  msg_o,
    output logic                  msg_oe,
    output logic                  req_o,
    output logic                  req_oe,
    output logic                  ack_o,
    output logic                  ack_oe,
    output logic                  atn_o,
    output logic                  atn_oe,
    output logic [7:0]            db_o,
    output logic [7:0]            db_oe,
    output logic                  dbp_o,
    output logic                  dbp_oe,
    input  wire logic [2:0]       my_id,
    input  wire logic [2:0]       peer_id,
    input  wire logic             arb_req,
    input  wire logic             resel_mode,
    input  wire logic             bus_reset_req,
    input  wire logic             tgt_cd,
    input  wire logic             tgt_io,
    input  wire logic             tgt_msg,
    input  wire logic             tgt_req,
    input  wire logic [7:0]       tgt_data,
    input  wire logic             tgt_disc,
    input  wire logic             init_ack,
    input  wire logic             init_atn,
    input  wire logic [7:0]       init_data,
    output logic [3:0]            phase,
    output logic [3:0]            state,
    output logic                  bus_free,
    output logic                  arb_won,
    output logic                  arb_lost
);
    // ----------------------------------------
    // bus free detection
    // ----------------------------------------
    logic             free_det;
    logic [AGE_W-1:0] free_age;

    sbp_free_det u_free (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .bsy_in   (bsy_in),
        .sel_in   (sel_in),
        .rst_in   (rst_in),
        .free_det (free_det),
        .free_age (free_age)
    );

    // ----------------------------------------
    // id decode and selection checks
    // ----------------------------------------
    logic [7:0] id_oh, higher_mask, sel_bits;
    logic [3:0] bit_cnt;
    logic       par_ok, sel_me, arb_window;

    assign id_oh       = DB_ONE << my_id;
    assign higher_mask = ~((id_oh << 1) - DB_ONE);
    assign sel_bits    = id_oh | (DB_ONE << peer_id);
    assign par_ok      = ^{db_in, dbp_in};
    assign sel_me      = sel_in && !bsy_in && (db_in & id_oh) != DB_NONE
                         && par_ok && bit_cnt <= 4'h2;
    // window: after free delay, before set delay
    assign arb_window  = free_det && free_age >= AGE_W'(N_FREE)
                         && free_age < AGE_W'(N_SET);

    always_comb begin
        bit_cnt = 4'h0;
        for (int i = 0; i < 8; i++) begin
            bit_cnt = bit_cnt + {3'h0, db_in[i]};
        end
    end

    // ----------------------------------------
    // control state machine
    // ----------------------------------------
    sbp_state_t       st_q, st_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic             won_q, won_d, lost_q, lost_d;

    always_comb begin
        st_d   = st_q;
        tmr_d  = (tmr_q == {TMR_W{1'b1}}) ? tmr_q : tmr_q + 1'b1;
        won_d  = 1'b0;
        lost_d = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (arb_req && arb_window) begin
                    st_d = ST_ARB;
                end else if (!sel_me) begin
                    tmr_d = '0;
                end else if (tmr_q >= TMR_W'(N_SETTLE)) begin
                    st_d = io_in ? ST_RSEL : ST_TGT;
                end
            end
            ST_ARB: begin
                if (sel_in || !arb_req) begin
                    st_d   = ST_IDLE;
                    lost_d = 1'b1;
                end else if (tmr_q >= TMR_W'(N_ARB)) begin
                    if ((db_in & higher_mask) != DB_NONE) begin
                        st_d   = ST_IDLE;
                        lost_d = 1'b1;
                    end else begin
                        st_d  = ST_WON;
                        won_d = 1'b1;
                    end
                end
            end
            ST_WON: begin
                if (tmr_q >= TMR_W'(N_CLEAR + N_SETTLE)) begin
                    st_d = ST_SEL;
                end
            end
            ST_SEL: begin
                if (!arb_req) begin
                    st_d = ST_IDLE;
                end else if (tmr_q >= TMR_W'(N_DESKEW2 + N_SETTLE) && bsy_in) begin
                    st_d = ST_SELW;
                end
            end
            ST_SELW: begin
                if (tmr_q >= TMR_W'(N_DESKEW2)) begin
                    st_d = resel_mode ? ST_TGT : ST_INIT;
                end
            end
            ST_TGT: begin
                if (tgt_disc) begin
                    st_d = ST_DISC;
                end
            end
            ST_RSEL: begin
                if (!sel_in) begin
                    st_d = ST_INIT;
                end
            end
            ST_INIT: begin
            end
            ST_DISC: begin
                if (tmr_q >= TMR_W'(DISC_CYC)) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        // a free bus ends any connection
        if (free_det && (st_q == ST_TGT || st_q == ST_INIT || st_q == ST_RSEL
                         || st_q == ST_SEL || st_q == ST_SELW)) begin
            st_d = ST_IDLE;
        end
        if (rst_in) begin
            st_d = ST_IDLE;
        end
        if (st_d != st_q) begin
            tmr_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q   <= ST_IDLE;
            tmr_q  <= '0;
            won_q  <= 1'b0;
            lost_q <= 1'b0;
        end else if (ce) begin
            st_q   <= st_d;
            tmr_q  <= tmr_d;
            won_q  <= won_d;
            lost_q <= lost_d;
        end
    end

    // ----------------------------------------
    // req / ack pulse stretcher
    // ----------------------------------------
    logic       stb_q, stb_d;
    logic [3:0] stb_cnt_q, stb_cnt_d;
    logic       stb_req;

    always_comb begin
        stb_req   = (st_d == ST_TGT) ? tgt_req : (st_d == ST_INIT && init_ack);
        // short request still gives full pulse
        stb_d     = (st_d == ST_TGT || st_d == ST_INIT)
                    && (stb_req || (stb_q && stb_cnt_q < 4'(N_ASSERT - 1)));
        stb_cnt_d = (stb_q && stb_cnt_q != 4'hf) ? stb_cnt_q + 1'b1 : 4'h0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stb_q     <= 1'b0;
            stb_cnt_q <= 4'h0;
        end else if (ce) begin
            stb_q     <= stb_d;
            stb_cnt_q <= stb_cnt_d;
        end
    end

    // ----------------------------------------
    // line drive per state
    // ----------------------------------------
    sbp_drv_t drv_q, drv_d;
    logic     rst_drv_q, rst_drv_d;

    always_comb begin
        drv_d     = DRV_NONE;
        rst_drv_d = bus_reset_req;
        case (st_d)
            ST_ARB: begin
                drv_d.bsy    = 1'b1;
                drv_d.db     = id_oh;
                drv_d.db_oe  = id_oh;
                drv_d.dbp    = 1'b1;
                drv_d.dbp_oe = 1'b1;
            end
            ST_WON, ST_SEL, ST_SELW: begin
                drv_d.sel    = 1'b1;
                // reselect shows I/O, select raises ATN
                drv_d.io_oe  = st_d != ST_WON && resel_mode;
                drv_d.io     = resel_mode;
                drv_d.atn    = st_d != ST_WON && !resel_mode;
                if (st_d == ST_WON) begin
                    drv_d.bsy    = 1'b1;
                    drv_d.db     = id_oh;
                    drv_d.db_oe  = id_oh;
                    drv_d.dbp    = 1'b1;
                    drv_d.dbp_oe = 1'b1;
                end else begin
                    drv_d.bsy    = (st_d == ST_SEL) ? tmr_d < TMR_W'(N_DESKEW2)
                                                    : resel_mode;
                    drv_d.db     = sel_bits;
                    drv_d.db_oe  = 8'hff;
                    drv_d.dbp    = ~^sel_bits;
                    drv_d.dbp_oe = 1'b1;
                end
            end
            ST_TGT: begin
                drv_d.bsy    = 1'b1;
                drv_d.cd_oe  = 1'b1;
                drv_d.cd     = tgt_cd;
                drv_d.io_oe  = 1'b1;
                drv_d.io     = tgt_io;
                drv_d.msg_oe = 1'b1;
                drv_d.msg    = tgt_msg;
                drv_d.req    = stb_d;
                if (tgt_io) begin
                    drv_d.db     = tgt_data;
                    drv_d.db_oe  = 8'hff;
                    drv_d.dbp    = ~^tgt_data;
                    drv_d.dbp_oe = 1'b1;
                end
            end
            ST_RSEL: begin
                drv_d.bsy = 1'b1;
            end
            ST_INIT: begin
                drv_d.ack = stb_d;
                drv_d.atn = init_atn;
                // data drops one cycle after I/O rises
                if (!io_in) begin
                    drv_d.db     = init_data;
                    drv_d.db_oe  = 8'hff;
                    drv_d.dbp    = ~^init_data;
                    drv_d.dbp_oe = 1'b1;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            drv_q     <= DRV_NONE;
            rst_drv_q <= 1'b0;
        end else if (ce) begin
            drv_q     <= drv_d;
            rst_drv_q <= rst_drv_d;
        end
    end

    // ----------------------------------------
    // phase tracking
    // ----------------------------------------
    sbp_phase_t ph_q, ph_d;
    logic       early;

    always_comb begin
        ph_d  = ph_q;
        early = (ph_q == PH_FREE || ph_q == PH_ARB);
        if (rst_in || free_det) begin
            ph_d = PH_FREE;
        end else if (sel_in) begin
            if (io_in) begin
                ph_d = PH_RESEL;
            end else if (ph_q == PH_ARB && bsy_in) begin
                ph_d = PH_ARB;
            end else begin
                ph_d = PH_SEL;
            end
        end else if (bsy_in) begin
            if (early) begin
                ph_d = PH_ARB;
            end else begin
                case ({cd_in, io_in, msg_in})
                    3'h0:    ph_d = PH_DATA_OUT;
                    3'h2:    ph_d = PH_DATA_IN;
                    3'h4:    ph_d = PH_COMMAND;
                    3'h6:    ph_d = PH_STATUS;
                    3'h5:    ph_d = PH_MSG_OUT;
                    3'h7:    ph_d = PH_MSG_IN;
                    default: ph_d = ph_q;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ph_q <= PH_FREE;
        end else if (ce) begin
            ph_q <= ph_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // wired-or lines assert true only
    assign bsy_o    = 1'b1;
    assign bsy_oe   = drv_q.bsy;
    assign sel_o    = 1'b1;
    assign sel_oe   = drv_q.sel;
    assign rst_o    = 1'b1;
    assign rst_oe   = rst_drv_q;
    assign cd_o     = drv_q.cd;
    assign cd_oe    = drv_q.cd_oe;
    assign io_o     = drv_q.io;
    assign io_oe    = drv_q.io_oe;
    assign msg_o    = drv_q.msg;
    assign msg_oe   = drv_q.msg_oe;
    assign req_o    = 1'b1;
    assign req_oe   = drv_q.req;
    assign ack_o    = 1'b1;
    assign ack_oe   = drv_q.ack;
    assign atn_o    = 1'b1;
    assign atn_oe   = drv_q.atn;
    assign db_o     = drv_q.db;
    assign db_oe    = drv_q.db_oe;
    assign dbp_o    = drv_q.dbp;
    assign dbp_oe   = drv_q.dbp_oe;
    assign phase    = ph_q;
    assign state    = st_q;
    assign bus_free = free_det;
    assign arb_won  = won_q;
    assign arb_lost = lost_q;
endmodule
`default_nettype wire

// ==== test/sbp_bus_ctrl_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbp_bus_ctrl_checker
    import sbp_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       bsy_in,
    input wire logic       sel_in,
    input wire logic       rst_in,
    input wire logic       io_in,
    input wire logic       bsy_o,
    input wire logic       bsy_oe,
    input wire logic       sel_oe,
    input wire logic       cd_oe,
    input wire logic       io_oe,
    input wire logic       msg_oe,
    input wire logic       req_oe,
    input wire logic       ack_oe,
    input wire logic       atn_oe,
    input wire logic [7:0] db_o,
    input wire logic [7:0] db_oe,
    input wire logic       dbp_o,
    input wire logic       dbp_oe,
    input wire logic [2:0] my_id,
    input wire logic [3:0] phase,
    input wire logic [3:0] state,
    input wire logic       bus_free,
    input wire logic       arb_won
);
    // ----------------------------------------
    // helper counters, quiet and age saturating
    // ----------------------------------------
    logic [7:0] qt_q, qt_d, age_q, age_d, arb_q, arb_d;
    logic       drv;
    assign drv = bsy_oe | sel_oe | cd_oe | io_oe | msg_oe | req_oe | ack_oe | atn_oe
               | (|db_oe) | dbp_oe;
    always_comb begin
        qt_d  = (bsy_in | sel_in | rst_in) ? 8'h00 : qt_q + {7'h00, qt_q != 8'hff};
        age_d = bus_free ? age_q + {7'h00, age_q != 8'hff} : 8'h00;
        arb_d = (state == ST_IDLE) ? 8'h00 : arb_q + {7'h00, bsy_oe && state == ST_ARB};
    end
    always_ff @(posedge clk) begin
        qt_q  <= rst ? 8'h00 : qt_d;
        age_q <= rst ? 8'h00 : age_d;
        arb_q <= rst ? 8'h00 : arb_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    free_idle_a: assert property (state == ST_IDLE && $past(state) == ST_IDLE |-> !drv)
        else $error("line driven while idle");
    or_drive_a: assert property (bsy_o)
        else $error("busy driven false");
    arb_id_a: assert property (state == ST_ARB && bsy_oe |->
        db_oe == (8'h01 << my_id) && (db_o & db_oe) == db_oe && (!dbp_oe || dbp_o))
        else $error("bad id drive in arbitration");
    sel_win_a: assert property ($rose(sel_oe) |-> arb_won || $past(arb_won))
        else $error("select without win");
    arb_wait_a: assert property (arb_won |-> arb_q >= N_ARB)
        else $error("arbitration decided early");
    free_det_a: assert property (bus_free |-> qt_q >= N_SETTLE - 1)
        else $error("bus free too early");
    free_rise_a: assert property (qt_q > N_SETTLE |-> bus_free)
        else $error("bus free missed");
    arb_window_a: assert property ($rose(bsy_oe) && state == ST_ARB |->
        age_q >= N_FREE && age_q <= N_SET + 2)
        else $error("arb outside window");
    rst_clear_a: assert property (rst_in |-> ##2 !drv && phase == 4'h0)
        else $error("lines kept after bus reset");
    ack_hold_a: assert property ($rose(ack_oe) |-> ack_oe[*5])
        else $error("ack pulse short");
    data_rel_a: assert property ($rose(io_in) && state == ST_INIT |-> ##[1:2] db_oe == 8'h00)
        else $error("data kept after io");
    cover property (arb_won);
    cover property ($rose(io_in) && state == ST_INIT);
    cover property (rst_in ##2 !drv);
endmodule
bind sbp_bus_ctrl sbp_bus_ctrl_checker chk (.*);
`default_nettype wire

// ==== test/sbp_peer_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbp_peer_model
    import sbp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic       hold,
    input  wire logic [2:0] id,
    input  wire logic       bsy_l,
    input  wire logic       sel_l,
    input  wire logic       rst_l,
    input  wire logic [7:0] db_l,
    output logic            bsy,
    output logic            sel,
    output logic [7:0]      db
);
    // ----------------------------------------
    // other device: asserts lines, no parity
    // ----------------------------------------
    logic [7:0] qt_q, qt_d, cnt_q, cnt_d;
    logic [1:0] st_q, st_d;
    assign bsy = st_q != 2'h0;
    assign sel = st_q == 2'h2;
    assign db  = (st_q[1] ^ st_q[0]) ? (8'h01 << id) : 8'h00;
    always_comb begin
        qt_d  = (bsy_l | sel_l | rst_l) ? 8'h00 : qt_q + {7'h00, qt_q != 8'hff};
        cnt_d = cnt_q + 8'h01;
        st_d  = st_q;
        case (st_q)
            2'h0: begin
                cnt_d = (sel_l && !bsy_l && db_l[id]) ? cnt_q + 8'h01 : 8'h00;
                if (cnt_q >= N_SETTLE && hold) begin
                    st_d = 2'h3;
                end else if (go && qt_q >= N_SETTLE + N_FREE && qt_q < N_SETTLE + N_SET) begin
                    st_d  = 2'h1;
                    cnt_d = 8'h00;
                end
            end
            2'h1: begin
                if (sel_l || (cnt_q >= N_ARB && (db_l >> id) > 8'h01)) begin
                    st_d = 2'h0;
                end else if (cnt_q >= N_ARB) begin
                    st_d  = 2'h2;
                    cnt_d = 8'h00;
                end
            end
            2'h2: st_d = (cnt_q >= N_CLEAR + N_SETTLE) ? 2'h0 : st_q;
            default: st_d = hold ? st_q : 2'h0;
        endcase
        if (rst_l) begin
            st_d = 2'h0;
        end
    end
    always_ff @(posedge clk) begin
        qt_q  <= rst ? 8'h00 : qt_d;
        cnt_q <= rst ? 8'h00 : cnt_d;
        st_q  <= rst ? 2'h0 : st_d;
    end
endmodule
`default_nettype wire

// ==== test/test_sbp_bus_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_sbp_bus_ctrl
    import sbp_pkg::*;
;
    typedef struct packed {logic [2:0] me; logic [2:0] pid; logic won;} sbp_row_t;
    // ----------------------------------------
    // bench
    // ----------------------------------------
    localparam int DISC = 100;
    localparam sbp_row_t ROWS [4] = '{'{3'h6, 3'h2, 1'b1}, '{3'h2, 3'h6, 1'b0},
                                      '{3'h0, 3'h7, 1'b0}, '{3'h7, 3'h0, 1'b1}};
    logic       clk, rst, ce, bsy_in, sel_in, rst_in, cd_in, io_in, msg_in, dbp_in;
    logic       req_in, ack_in, atn_in, bsy_o, bsy_oe, sel_o, sel_oe, rst_o, rst_oe;
    logic       cd_o, cd_oe, io_o, io_oe, msg_o, msg_oe, req_o, req_oe, ack_o, ack_oe;
    logic       atn_o, atn_oe, dbp_o, dbp_oe, bus_free, arb_won, arb_lost, arb_req;
    logic       resel_mode, bus_reset_req, tgt_cd, tgt_io, tgt_msg, tgt_req, tgt_disc;
    logic       init_ack, init_atn, tb_sel, tb_io, p_go, p_hold, p_bsy, p_sel;
    logic [7:0] db_in, db_o, db_oe, tgt_data, init_data, tb_db, p_db;
    logic [2:0] my_id, peer_id, p_id;
    logic [3:0] phase, state;
    int         err_total, n_checks, n, i;
    assign bsy_in = bsy_oe | p_bsy;
    assign sel_in = sel_oe | p_sel | tb_sel;
    assign rst_in = rst_oe;
    assign db_in  = (db_oe & db_o) | p_db | tb_db;
    assign dbp_in = (dbp_oe & dbp_o) | (tb_sel & ~^tb_db);
    assign io_in  = io_oe ? io_o : tb_io;
    assign cd_in  = cd_oe & cd_o;
    assign msg_in = msg_oe & msg_o;
    assign req_in = req_oe;
    assign ack_in = ack_oe;
    assign atn_in = atn_oe;
    sbp_bus_ctrl #(.DISC_CYC(DISC)) dut (.*);
    sbp_peer_model peer (.clk(clk), .rst(rst), .go(p_go), .hold(p_hold), .id(p_id),
        .bsy_l(bsy_in), .sel_l(sel_in), .rst_l(rst_in), .db_l(db_in), .bsy(p_bsy),
        .sel(p_sel), .db(p_db));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("wrong value at %0t ns: %s", $time, m);
        end
    endtask
    function automatic logic seen(input int w);
        case (w)
            0: return bus_free === 1'b1;
            1: return (arb_won | arb_lost) === 1'b1;
            2: return state === ST_INIT;
            default: return bsy_oe === 1'b1;
        endcase
    endfunction
    task automatic wait_for(input int w, input int lim);
        n = 0;
        while (!seen(w) && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (n >= lim) begin
            err_total++;
            $display("wrong value at %0t ns: wait %0d ran out", $time, w);
            close_out();
        end
    endtask
    task automatic pulse_len(input logic use_req, output int len);
        len = 0;
        repeat (12) begin
            @(negedge clk);
            tgt_req = 1'b0;
            init_ack = 1'b0;
            len += int'(use_req ? req_oe : ack_oe);
        end
    endtask
    initial begin
        {ce, resel_mode, tgt_cd, tgt_msg} = 4'h8;
        {arb_req, bus_reset_req, tgt_io, tgt_req, tgt_disc, init_ack, init_atn} = '0;
        {tb_sel, tb_io, p_go, p_hold, my_id, peer_id, p_id} = '0;
        {tgt_data, init_data, tb_db, err_total, n_checks} = '0;
        rst = 1'b1;
        repeat (20) @(negedge clk);
        chk({bsy_oe, sel_oe, rst_oe, db_oe, state, phase, bus_free} === '0, "reset");
        rst = 1'b0;
        wait_for(0, 100);
        chk(n >= N_SETTLE && n <= N_SETTLE + 1, "free delay");
        $display("test reset finished");
        for (i = 0; i < 4; i++) begin
            my_id = ROWS[i].me;
            p_id = ROWS[i].pid;
            {arb_req, p_go} = 2'h3;
            wait_for(1, 400);
            chk(arb_won === ROWS[i].won, "arb outcome");
            chk(n >= N_FREE + N_ARB - 4 && n <= N_SET + N_ARB + 4, "arb time");
            {arb_req, p_go} = 2'h0;
            wait_for(0, 300);
        end
        $display("test arbitration finished");
        {my_id, peer_id, p_id, p_hold, init_atn, init_data} = {9'h0ed, 2'h3, 8'ha5};
        arb_req = 1'b1;
        wait_for(2, 800);
        repeat (2) @(negedge clk);
        chk(db_oe === 8'hff && db_o === init_data && dbp_o === ~^init_data, "out");
        chk({atn_oe, sel_oe, bsy_oe} === 3'h4 && phase === PH_DATA_OUT, "init");
        init_ack = 1'b1;
        pulse_len(1'b0, n);
        chk(n >= N_ASSERT && n <= N_ASSERT + 2, "ack length");
        tb_io = 1'b1;
        repeat (3) @(negedge clk);
        chk(db_oe === 8'h00 && phase === PH_DATA_IN, "data in");
        {arb_req, bus_reset_req} = 2'h1;
        @(negedge clk);
        chk(rst_oe === 1'b1, "bus reset drive");
        repeat (3) @(negedge clk);
        chk({db_oe, atn_oe, ack_oe, sel_oe, bsy_oe, phase} === '0, "reset release");
        {bus_reset_req, tb_io, p_hold, init_atn} = 4'h0;
        wait_for(0, 300);
        $display("test initiator finished");
        {my_id, tb_db, tb_sel} = {3'h3, 8'h09, 1'b1};
        wait_for(3, 100);
        chk(n >= N_SETTLE, "select settle");
        {tb_sel, tb_db, tgt_io, tgt_data} = {9'h000, 1'b1, 8'h3c};
        repeat (2) @(negedge clk);
        chk(db_oe === 8'hff && db_o === tgt_data && dbp_o === ~^tgt_data, "tdata");
        chk({io_oe, io_o, cd_oe, cd_o} === 4'he && phase === PH_DATA_IN, "tphase");
        tgt_req = 1'b1;
        pulse_len(1'b1, n);
        chk(n >= N_ASSERT && n <= N_ASSERT + 2, "req length");
        tgt_disc = 1'b1;
        @(negedge clk);
        tgt_disc = 1'b0;
        repeat (2) @(negedge clk);
        chk({bsy_oe, io_oe, db_oe} === '0 && state === ST_DISC, "disconnect");
        arb_req = 1'b1;
        wait_for(3, 300);
        chk(n >= DISC - 3, "rearbitration wait");
        arb_req = 1'b0;
        wait_for(0, 300);
        $display("test target finished");
        close_out();
    end
endmodule
`default_nettype wire
